// >>> include/snoop_pkg.sv
// Purpose: Shared types and constants for the snoop latch control block.
// Assumes: 32-bit snoop address, APB register access with 32-bit data.
// Notes:   Offsets are byte addresses; every register is one aligned word.
package snoop_pkg;

    localparam int ADDR_W = 32;

    // Captured snoop address and attributes
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic              parity;
        logic              inval;
        logic              noncache;
        logic              bus_aoe_n;
        logic              mem_aoe_n;
    } snoop_bits_s;

    localparam int BITS_W = $bits(snoop_bits_s);
    localparam int SYNC_W = BITS_W + 7;

    // Sync vector reset: strobes, guarantee and window close idle high
    localparam logic [SYNC_W-1:0] SYNC_RST = {7'h4c, {BITS_W{1'b1}}};

    typedef enum logic [2:0] {
        MODE_SYNC    = 3'b001,
        MODE_STROBE  = 3'b010,
        MODE_CLOCKED = 3'b100
    } latch_mode_e;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b01,
        ST_LOOKUP = 2'b10
    } lookup_state_e;

    typedef enum logic [1:0] {
        LINE_I = 2'h0,
        LINE_S = 2'h1,
        LINE_E = 2'h2,
        LINE_M = 2'h3
    } line_state_e;

    // Tag array answer, valid one cycle after the lookup request
    typedef struct packed {
        logic        hit;
        line_state_e state;
    } tag_result_s;

    // Register offsets
    localparam logic [7:0] CTRL_OFF   = 8'h00;
    localparam logic [7:0] STATUS_OFF = 8'h04;
    localparam logic [7:0] ADDR_OFF   = 8'h08;
    localparam logic [7:0] ATTR_OFF   = 8'h0c;

    // Field positions
    localparam int CTRL_EN_BIT     = 0;
    localparam int STAT_OVR_BIT    = 6;
    localparam logic [31:0] CTRL_RST = 32'h0000_0001;

    // Samples of the shared mode pin taken while reset is held
    localparam int MODE_SAMPLES = 4;

endpackage

// >>> core/snoop_sync2.sv
// Purpose: Two-flop synchroniser for a vector of pin levels into core_clk.
// Assumes: Each bit is an independent level or is qualified by another bit.
// Notes:   The first stage is read only by the second stage.
`timescale 1ns/1ns
`default_nettype none
module snoop_sync2 #(
    parameter int             W       = 1,
    parameter logic [W-1:0]   RST_VAL = '0
) (
    input  wire logic         core_clk,
    input  wire logic         core_ce,
    input  wire logic         sys_rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            meta_q <= RST_VAL;
            q      <= RST_VAL;
        end else if (core_ce) begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule
`default_nettype wire

// >>> core/snoop_link_capture.sv
// Purpose: Snoop latch running on a link-side clock (snoop clock or strobe).
// Assumes: Pins are stable around the capturing edge of cap_clk.
// Notes:   Each capture flips toggle_q; the core reads bits_q after the toggle
//          has crossed, so bits_q must not change again for a few core cycles.
`timescale 1ns/1ns
`default_nettype none
module snoop_link_capture #(
    parameter bit CHECK_EDGE = 1'b1
) (
    input  wire logic                   cap_clk,
    input  wire logic                   cap_rst,
    input  wire logic                   strobe_n,
    input  wire snoop_pkg::snoop_bits_s bits_in,
    output snoop_pkg::snoop_bits_s      bits_q,
    output logic                        toggle_q
);
    logic      strobe_prev_q;
    wire logic take;

    // Clocked mode takes the edge where the strobe turns active
    assign take = CHECK_EDGE ? (!strobe_n && strobe_prev_q) : 1'b1;

    always_ff @(posedge cap_clk or posedge cap_rst) begin
        if (cap_rst) begin
            strobe_prev_q <= 1'b1;
            toggle_q      <= 1'b0;
            bits_q        <= '0;
        end else begin
            strobe_prev_q <= strobe_n;
            if (take) begin
                bits_q   <= bits_in;
                toggle_q <= ~toggle_q;
            end
        end
    end
endmodule
`default_nettype wire

// >>> core/snoop_latch_control.sv
// Purpose: Snoop latch, lookup scheduling and snoop window handling.
// Assumes: Tag array answers one core_clk cycle after tag_lookup_req.
// Notes:   Latching mode is taken from the shared mode/clock pin at reset.
// How it works
// - Capture snoops while delayed, postpone lookup
// - Delay on modified hit or back-invalidation
// - No lookup starts while delay asserted
// - Clocked mode samples pins on snoop clock
// - Flag lookup; hit outputs valid next clock
// - Invalidate attribute sends hit line invalid
// - Mode pin at reset selects latching mode
// - Non-caching master flag sampled with strobe
// - Non-caching master keeps E/M lines
// - Active strobe captures snoop and launches it
// - Clocked mode captures on active strobe edge
// - Strobed mode captures on strobe falling edge
// - Synchronous mode captures on core clock edge
// - Window close latches write policy attributes
// - Guarantee blocks snooping until a window close in a later cycle
`timescale 1ns/1ns
`default_nettype none
module snoop_latch_control (
    input  wire logic                   core_clk,
    input  wire logic                   core_ce,
    input  wire logic                   sys_rst,
    input  wire logic                   snoop_sample_clock,
    input  wire logic                   snoop_strobe_n,
    input  wire logic                   snoop_invalidate,
    input  wire logic                   noncaching_master,
    input  wire logic                   bus_address_oe_n,
    input  wire logic                   memory_address_oe_n,
    input  wire logic                   addr_parity,
    input  wire logic [31:0]            snoop_address,
    input  wire logic                   cycle_guarantee_n,
    input  wire logic                   window_close_n,
    input  wire logic                   write_policy,
    input  wire logic                   direct_memory_xfer,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [7:0]             paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    output logic                        tag_lookup_req,
    output logic      [31:0]            tag_lookup_addr,
    input  wire snoop_pkg::tag_result_s tag_result,
    input  wire logic                   backinv_needed,
    input  wire logic                   writeback_done,
    input  wire logic                   backinv_done,
    output logic                        tag_write_en,
    output snoop_pkg::line_state_e      tag_write_state,
    output logic                        snoop_delay_n,
    output logic                        lookup_active_n,
    output logic                        hit_modified_n,
    output logic                        tag_hit_n,
    output logic                        tag_update_ok,
    output logic                        latched_write_policy,
    output logic                        latched_direct_xfer
);
    // Next line state after a snoop hit
    function automatic snoop_pkg::line_state_e snoop_next_state(
        input snoop_pkg::line_state_e cur,
        input logic                   inval,
        input logic                   noncache
    );
        if (inval)
            return snoop_pkg::LINE_I;
        else if (noncache || cur == snoop_pkg::LINE_I)
            return cur;
        else
            return snoop_pkg::LINE_S;
    endfunction

    // Pin bits and link-side latches
    snoop_pkg::snoop_bits_s pin_bits;
    snoop_pkg::snoop_bits_s clk_bits;
    snoop_pkg::snoop_bits_s stb_bits;
    snoop_pkg::snoop_bits_s sync_bits;
    logic                   clk_tog;
    logic                   stb_tog;
    wire logic              strobe_clk;

    assign pin_bits = '{addr: snoop_address, parity: addr_parity, inval: snoop_invalidate,
                        noncache: noncaching_master, bus_aoe_n: bus_address_oe_n,
                        mem_aoe_n: memory_address_oe_n};
    assign strobe_clk = ~snoop_strobe_n;

    snoop_link_capture #(.CHECK_EDGE(1'b1)) u_clocked_cap (
        .cap_clk  (snoop_sample_clock),
        .cap_rst  (sys_rst),
        .strobe_n (snoop_strobe_n),
        .bits_in  (pin_bits),
        .bits_q   (clk_bits),
        .toggle_q (clk_tog)
    );

    snoop_link_capture #(.CHECK_EDGE(1'b0)) u_strobed_cap (
        .cap_clk  (strobe_clk),
        .cap_rst  (sys_rst),
        .strobe_n (snoop_strobe_n),
        .bits_in  (pin_bits),
        .bits_q   (stb_bits),
        .toggle_q (stb_tog)
    );

    // All pin levels except the mode pin, and the link toggles, enter the core domain here
    logic [snoop_pkg::SYNC_W-1:0] sync_q;
    wire logic                    strobe_s;
    wire logic                    clk_tog_s;
    wire logic                    stb_tog_s;
    wire logic                    guar_s;
    wire logic                    close_s;
    wire logic                    wpol_s;
    wire logic                    dmx_s;

    snoop_sync2 #(.W(snoop_pkg::SYNC_W), .RST_VAL(snoop_pkg::SYNC_RST)) u_sync (
        .core_clk (core_clk),
        .core_ce  (core_ce),
        .sys_rst  (sys_rst),
        .d        ({snoop_strobe_n, clk_tog, stb_tog, cycle_guarantee_n,
                    window_close_n, write_policy, direct_memory_xfer, pin_bits}),
        .q        (sync_q)
    );

    assign {strobe_s, clk_tog_s, stb_tog_s, guar_s, close_s, wpol_s, dmx_s, sync_bits} = sync_q;

    // Core-side state
    logic [snoop_pkg::MODE_SAMPLES-1:0] mode_hist_q;
    logic [1:0]                         mode_sync_q;
    logic                               look_inval_q;
    logic                               look_nc_q;
    logic                               rst_prev_q;
    snoop_pkg::latch_mode_e             mode_q;
    logic                               strobe_prev_q;
    logic                               clk_tog_prev_q;
    logic                               stb_tog_prev_q;
    logic                               guar_prev_q;
    logic                               close_prev_q;
    snoop_pkg::snoop_bits_s             held_q;
    logic                               pending_q;
    logic                               overrun_q;
    logic                               mod_pend_q;
    logic                               binv_pend_q;
    logic                               guard_q;
    snoop_pkg::lookup_state_e           state_q;
    logic                               last_hit_q;
    logic                               last_mod_q;
    logic [31:0]                        ctrl_q;

    // Mode pin: held high is strobed, low is synchronous, toggling is clocked
    // Own unreset synchroniser, so the pin is seen while reset is held
    always_ff @(posedge core_clk) begin
        if (core_ce) begin
            mode_sync_q <= {mode_sync_q[0], snoop_sample_clock};
            rst_prev_q  <= sys_rst;
            if (sys_rst)
                mode_hist_q <= {mode_hist_q[snoop_pkg::MODE_SAMPLES-2:0], mode_sync_q[1]};
        end
    end

    wire logic                   rst_release;
    wire snoop_pkg::latch_mode_e mode_d;

    assign rst_release = rst_prev_q && !sys_rst;
    assign mode_d      = (&mode_hist_q) ? snoop_pkg::MODE_STROBE :
                         (|mode_hist_q) ? snoop_pkg::MODE_CLOCKED : snoop_pkg::MODE_SYNC;

    always_ff @(posedge core_clk) begin
        if (core_ce && rst_release)
            mode_q <= mode_d;
    end

    // Snoop arrival, one decode per latching mode
    wire logic                   strobe_fall;
    wire logic                   snoop_event;
    wire snoop_pkg::snoop_bits_s event_bits;
    wire logic                   guar_fall;
    wire logic                   close_fall;

    assign strobe_fall = strobe_prev_q && !strobe_s;
    assign snoop_event = (mode_q == snoop_pkg::MODE_SYNC)    ? strobe_fall :
                         (mode_q == snoop_pkg::MODE_CLOCKED) ? (clk_tog_s ^ clk_tog_prev_q) :
                                                               (stb_tog_s ^ stb_tog_prev_q);
    assign event_bits  = (mode_q == snoop_pkg::MODE_SYNC)    ? sync_bits :
                         (mode_q == snoop_pkg::MODE_CLOCKED) ? clk_bits : stb_bits;
    assign guar_fall   = guar_prev_q && !guar_s;
    assign close_fall  = close_prev_q && !close_s;

    // Lookup scheduling
    wire logic delay_act;
    wire logic start;
    wire logic in_lookup;
    wire logic mod_hit;

    assign delay_act = mod_pend_q || binv_pend_q;
    assign start     = state_q == snoop_pkg::ST_IDLE && pending_q && !delay_act && !guard_q
                       && ctrl_q[snoop_pkg::CTRL_EN_BIT];
    assign in_lookup = state_q == snoop_pkg::ST_LOOKUP;
    assign mod_hit   = in_lookup && tag_result.hit && tag_result.state == snoop_pkg::LINE_M;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            strobe_prev_q  <= 1'b1;
            clk_tog_prev_q <= 1'b0;
            stb_tog_prev_q <= 1'b0;
            guar_prev_q    <= 1'b1;
            close_prev_q   <= 1'b1;
        end else if (core_ce) begin
            strobe_prev_q  <= strobe_s;
            clk_tog_prev_q <= clk_tog_s;
            stb_tog_prev_q <= stb_tog_s;
            guar_prev_q    <= guar_s;
            close_prev_q   <= close_s;
        end
    end

    // Snoop latch: a held snoop is never overwritten before its lookup
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            held_q    <= '0;
            pending_q <= 1'b0;
        end else if (core_ce) begin
            if (snoop_event && (!pending_q || start)) begin
                held_q    <= event_bits;
                pending_q <= 1'b1;
            end else if (start) begin
                pending_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst)
            state_q <= snoop_pkg::ST_IDLE;
        else if (core_ce) begin
            unique case (state_q)
                snoop_pkg::ST_IDLE:   if (start) state_q <= snoop_pkg::ST_LOOKUP;
                snoop_pkg::ST_LOOKUP: state_q <= snoop_pkg::ST_IDLE;
                default:              state_q <= snoop_pkg::ST_IDLE;
            endcase
        end
    end

    // Lookup results and line update
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            last_hit_q      <= 1'b0;
            last_mod_q      <= 1'b0;
            look_inval_q    <= 1'b0;
            look_nc_q       <= 1'b0;
            tag_write_en    <= 1'b0;
            tag_write_state <= snoop_pkg::LINE_I;
        end else if (core_ce) begin
            tag_write_en <= in_lookup && tag_result.hit;
            // The latch may refill at the start edge, so keep this lookup's attributes
            if (start) begin
                look_inval_q <= held_q.inval;
                look_nc_q    <= held_q.noncache;
            end
            if (in_lookup) begin
                last_hit_q      <= tag_result.hit;
                last_mod_q      <= mod_hit;
                tag_write_state <= snoop_next_state(tag_result.state, look_inval_q,
                                                    look_nc_q);
            end
        end
    end

    // Delay flags: a new cause wins over a completion in the same cycle
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            mod_pend_q  <= 1'b0;
            binv_pend_q <= 1'b0;
        end else if (core_ce) begin
            if (mod_hit)
                mod_pend_q <= 1'b1;
            else if (writeback_done)
                mod_pend_q <= 1'b0;
            if (in_lookup && tag_result.hit && backinv_needed)
                binv_pend_q <= 1'b1;
            else if (backinv_done)
                binv_pend_q <= 1'b0;
        end
    end

    // Snoop window: guarantee blocks lookups until a window close in a later cycle
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            guard_q              <= 1'b0;
            tag_update_ok        <= 1'b0;
            latched_write_policy <= 1'b0;
            latched_direct_xfer  <= 1'b0;
        end else if (core_ce) begin
            tag_update_ok <= close_fall && (guard_q || guar_fall);
            if (guar_fall)
                guard_q <= 1'b1;
            else if (close_fall)
                guard_q <= 1'b0;
            if (close_fall) begin
                latched_write_policy <= wpol_s;
                latched_direct_xfer  <= dmx_s;
            end
        end
    end

    assign tag_lookup_req  = core_ce && start;
    assign tag_lookup_addr = held_q.addr;
    assign snoop_delay_n   = ~delay_act;
    assign lookup_active_n = ~in_lookup;
    assign hit_modified_n  = ~last_mod_q;
    assign tag_hit_n       = ~last_hit_q;

    // APB slave, zero wait states
    wire logic        setup;
    wire logic        wr_acc;
    wire logic        mapped;
    wire logic [31:0] status_word;
    wire logic [31:0] attr_word;
    wire logic [31:0] rd_mux;

    assign setup  = psel && !penable;
    assign wr_acc = psel && penable && pwrite;
    assign mapped = paddr == snoop_pkg::CTRL_OFF || paddr == snoop_pkg::STATUS_OFF ||
                    paddr == snoop_pkg::ADDR_OFF || paddr == snoop_pkg::ATTR_OFF;
    assign status_word = {24'h0, in_lookup, overrun_q, guard_q, pending_q, delay_act, mode_q};
    assign attr_word   = {23'h0, last_mod_q, last_hit_q, latched_direct_xfer, latched_write_policy,
                          held_q.mem_aoe_n, held_q.bus_aoe_n, held_q.parity, held_q.noncache, held_q.inval};
    assign rd_mux = (paddr == snoop_pkg::CTRL_OFF)   ? ctrl_q :
                    (paddr == snoop_pkg::STATUS_OFF) ? status_word :
                    (paddr == snoop_pkg::ADDR_OFF)   ? held_q.addr :
                    (paddr == snoop_pkg::ATTR_OFF)   ? attr_word : 32'h0;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ctrl_q    <= snoop_pkg::CTRL_RST;
            overrun_q <= 1'b0;
            prdata    <= 32'h0;
        end else if (core_ce) begin
            if (setup)
                prdata <= rd_mux;
            if (wr_acc && paddr == snoop_pkg::CTRL_OFF)
                ctrl_q <= {31'h0, pwdata[snoop_pkg::CTRL_EN_BIT]};
            if (snoop_event && pending_q && !start)
                overrun_q <= 1'b1;
            else if (wr_acc && paddr == snoop_pkg::STATUS_OFF && pwdata[snoop_pkg::STAT_OVR_BIT])
                overrun_q <= 1'b0;
        end
    end

    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst || !core_ce);

    delay_blocks_lookup_a: assert property (!snoop_delay_n |-> !tag_lookup_req)
        else $error("lookup started while snoop delay asserted");
    guard_blocks_lookup_a: assert property (guard_q |-> !tag_lookup_req)
        else $error("lookup started inside guaranteed window");
    active_one_cycle_a: assert property (tag_lookup_req |=> !lookup_active_n ##1 lookup_active_n)
        else $error("lookup active not a single cycle after request");
    hit_follows_a: assert property (!lookup_active_n && tag_result.hit |=> !tag_hit_n)
        else $error("tag hit output not valid after lookup");
    modified_delay_a: assert property (!lookup_active_n && tag_result.hit && tag_result.state == snoop_pkg::LINE_M
        |=> !snoop_delay_n && !hit_modified_n)
        else $error("modified hit did not raise snoop delay");
    held_stable_a: assert property (pending_q && !start |=> $stable(held_q))
        else $error("held snoop changed before its lookup");
    inval_state_a: assert property (tag_lookup_req && held_q.inval ##1 tag_result.hit
        |=> tag_write_en && tag_write_state == snoop_pkg::LINE_I)
        else $error("invalidating snoop did not end invalid");
    noncache_keep_a: assert property (tag_lookup_req && !held_q.inval && held_q.noncache ##1 tag_result.hit
        |=> tag_write_state == $past(tag_result.state))
        else $error("non-caching snoop changed line state");
    sync_capture_a: assert property (mode_q == snoop_pkg::MODE_SYNC && strobe_fall && !pending_q
        |=> pending_q && held_q == $past(sync_bits))
        else $error("synchronous snoop not captured");
    window_latch_a: assert property (close_fall |=> latched_write_policy == $past(wpol_s)
        && latched_direct_xfer == $past(dmx_s))
        else $error("window close did not latch attributes");
    delayed_capture_a: assert property (delay_act && snoop_event && !pending_q |=> pending_q)
        else $error("snoop lost while lookups delayed");

    lookup_seen_c: cover property (tag_lookup_req ##1 !lookup_active_n);
    delayed_snoop_c: cover property (delay_act && pending_q ##[1:50] tag_lookup_req);
    window_close_c: cover property (guard_q ##[1:50] tag_update_ok);
    overrun_c: cover property (snoop_event && pending_q && !start);
endmodule
`default_nettype wire

// >>> tb/snoop_tag_model.sv
// Purpose: Tag array stand-in that answers each lookup one cycle later.
// Assumes: Hit when address bit 2 is set and bits [1:0] give a non-I state.
// Notes:   Outside its answer cycle the result flips every cycle.
`timescale 1ns/1ns
`default_nettype none
module snoop_tag_model (
    input  wire logic              core_clk,
    input  wire logic              tag_lookup_req,
    input  wire logic [31:0]       tag_lookup_addr,
    output snoop_pkg::tag_result_s tag_result
);
    wire logic hit_w = tag_lookup_addr[2] & (|tag_lookup_addr[1:0]);
    initial tag_result = '0;
    always @(posedge core_clk) begin
        if (tag_lookup_req) begin
            tag_result <= {hit_w, tag_lookup_addr[1:0]};
        end else begin
            tag_result <= ~tag_result;
        end
    end
endmodule
`default_nettype wire

// >>> tb/snoop_latch_control_tb.sv
// Purpose: Self-checking bench for the snoop latch in all three latching modes.
// Assumes: The snoop clock runs freely through the first reset; the later resets hold it at a fixed level.
// Notes:   Line states follow from address bits, as in the tag stand-in.
`timescale 1ns/1ns
`default_nettype none
module snoop_latch_control_tb;
    logic        clk = 0, rst = 1, sclk = 0, stb_n = 1, inv = 0, nc = 0, g_n = 1, c_n = 1, wpol = 0;
    logic        psel = 0, penable = 0, pwrite = 0, wb = 0, dmx = 0, err, upd_seen, pready, req, twe;
    logic        dly_n, act_n, hm_n, th_n, upd, lwp, ldx, spin_free = 1, spin_lvl = 0;
    logic [1:0]  twst;
    logic [7:0]  paddr = '0;
    logic [31:0] pwdata = '0, addr = '0, prdata, laddr, rd, lfsr = 32'h07ec;
    snoop_pkg::tag_result_s tres;
    int          n_mismatch = 0, checked = 0;
    always #10 clk = ~clk;
    always begin
        #7 sclk = ~sclk;
        #8 sclk = ~sclk;
    end
    snoop_latch_control i_dut (.core_clk(clk), .core_ce(1'b1), .sys_rst(rst),
        .snoop_sample_clock(spin_free ? sclk : spin_lvl),
        .snoop_strobe_n(stb_n), .snoop_invalidate(inv), .noncaching_master(nc), .bus_address_oe_n(addr[10]),
        .memory_address_oe_n(addr[11]), .addr_parity(^addr), .snoop_address(addr), .cycle_guarantee_n(g_n),
        .window_close_n(c_n), .write_policy(wpol), .direct_memory_xfer(dmx), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(err),
        .tag_lookup_req(req), .tag_lookup_addr(laddr), .tag_result(tres), .backinv_needed(laddr[3]),
        .writeback_done(wb), .backinv_done(wb), .tag_write_en(twe), .tag_write_state(twst),
        .snoop_delay_n(dly_n), .lookup_active_n(act_n), .hit_modified_n(hm_n), .tag_hit_n(th_n),
        .tag_update_ok(upd), .latched_write_policy(lwp), .latched_direct_xfer(ldx));
    snoop_tag_model i_tags (.core_clk(clk), .tag_lookup_req(req), .tag_lookup_addr(laddr), .tag_result(tres));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    task automatic close_out;
        if (n_mismatch == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    function automatic logic [31:0] nxt(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    // New line state on a hit
    function automatic logic [1:0] nst(input logic [1:0] s, input logic i, input logic n);
        return i ? 2'h0 : ((n || s == 2'h0) ? s : 2'h1);
    endfunction
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge clk);
        psel <= 1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        chk(err, a > 8'h0c);
        psel <= 0;
        penable <= 0;
    endtask
    task automatic snoop(input logic [31:0] a, input logic i, input logic n);
        @(posedge clk);
        addr <= a;
        inv <= i;
        nc <= n;
        @(posedge clk);
        stb_n <= 0;
        repeat (2) @(posedge clk);
        stb_n <= 1;
    endtask
    task automatic pulse_wb;
        @(posedge clk);
        wb <= 1;
        @(posedge clk);
        wb <= 0;
    endtask
    task automatic look(input logic [31:0] a, input logic i, input logic n);
        logic h;
        logic m;
        h = a[2] & (|a[1:0]);
        m = h && a[1:0] == 2'h3;
        upd_seen = 0;
        for (int k = 0; k < 40 && req !== 1'b1; k++) begin
            @(negedge clk);
            upd_seen |= upd === 1'b1;
        end
        chk(laddr, a);
        @(negedge clk);
        chk(act_n, 0);
        @(negedge clk);
        chk(th_n, !h);
        chk(hm_n, !m);
        chk(twe, h);
        if (h) chk(twst, nst(a[1:0], i, n));
        chk(dly_n, !(m || (h && a[3])));
    endtask
    initial begin
        repeat (10) @(posedge clk);
        rst <= 0;
        repeat (4) @(posedge clk);
        apb(snoop_pkg::STATUS_OFF, 0, 0);
        chk(rd[2:0], 3'h4);
        apb(8'h40, 0, 0);
        chk(rd, 0);
        for (int k = 0; k < 10; k++) begin
            lfsr = nxt(lfsr);
            snoop(lfsr, lfsr[8], lfsr[9]);
            look(lfsr, lfsr[8], lfsr[9]);
            if (lfsr[2] && |lfsr[1:0] && (&lfsr[1:0] || lfsr[3])) pulse_wb();
        end
        apb(snoop_pkg::CTRL_OFF, 1, 32'h0);
        snoop(32'h0000_1007, 0, 0);
        repeat (6) begin
            @(negedge clk);
            chk(req, 0);
        end
        apb(snoop_pkg::STATUS_OFF, 0, 0);
        chk(rd[4], 1);
        apb(snoop_pkg::CTRL_OFF, 1, 32'h1);
        look(32'h0000_1007, 0, 0);
        snoop(32'h0000_2006, 1, 0);
        repeat (12) begin
            @(negedge clk);
            chk(req, 0);
        end
        apb(snoop_pkg::ADDR_OFF, 0, 0);
        chk(rd, 32'h0000_2006);
        apb(snoop_pkg::ATTR_OFF, 0, 0);
        chk(rd, 32'h0000_0185);
        pulse_wb();
        look(32'h0000_2006, 1, 0);
        @(posedge clk);
        g_n <= 0;
        wpol <= 1;
        dmx <= 1;
        repeat (5) @(posedge clk);
        snoop(32'h0000_3006, 0, 1);
        repeat (8) begin
            @(negedge clk);
            chk(req, 0);
        end
        @(posedge clk);
        c_n <= 0;
        look(32'h0000_3006, 0, 1);
        chk(upd_seen, 1);
        chk(lwp, 1);
        chk(ldx, 1);
        for (int md = 0; md < 2; md++) begin
            @(posedge clk);
            rst <= 1;
            g_n <= 1;
            c_n <= 1;
            spin_free <= 0;
            spin_lvl <= md[0];
            repeat (10) @(posedge clk);
            rst <= 0;
            repeat (4) @(posedge clk);
            apb(snoop_pkg::STATUS_OFF, 0, 0);
            chk(rd[2:0], md[0] ? 3'h2 : 3'h1);
            snoop(32'h0000_4005 + md, md[0], 0);
            look(32'h0000_4005 + md, md[0], 0);
        end
        close_out();
    end
    initial begin
        #100000;
        n_mismatch++;
        close_out();
    end
endmodule
`default_nettype wire
